/* File: logic/lds_tx_top.sv */
`timescale 1ns/1ps
module lds_tx_top (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Clock sources from the timer
    input wire logic fast_clock_source,
    input wire logic slow_clock_source,
    // Start lines
    input wire logic ext_start_in,
    output logic sync_start_out,
    // Pins
    output logic serial_out_pin,
    output logic double_rate_clock_out,
    output logic shift_clock_out,
    // Events
    output logic group_done_event,
    output logic frame_done_event
);
    // Lane between frame control and shifter
    lds_lane_if lane ();

    // Clock source synchronisers
    logic fc_s1, fc_s2, fc_s3;
    logic sc_s1, sc_s2, sc_s3;
    // Filtered clock levels
    logic fc_level_r, sc_level_r;
    // Falling edge of the double-rate clock
    logic fall_edge;
    // Software registers
    logic [2:0] ctrl_r;
    logic [7:0] len_r;
    logic overflow_r, underflow_r;
    // Frame sequencer
    lds_pkg::lds_seq_e state_r, state_nxt;
    logic transfer_start;
    logic not_active;
    // Word and bit counters
    logic [8:0] wcnt_r;
    logic word_count_match;
    logic [4:0] bit_idx_r;
    logic bit_count_match;
    logic head_r;
    // Transmit word queue
    logic [15:0] q_mem [lds_pkg::QUEUE_DEPTH];
    logic [1:0] q_wr_r, q_rd_r;
    logic [2:0] q_lvl_r;
    logic q_push, q_pop, q_empty, q_starve;
    // Register strobes
    logic wr_ctrl, wr_len, wr_data, wr_status;
    // Frame event register
    logic frame_done_r;
    // Forwarded shift clock
    logic shift_clk_r;

    // Three-stage synchronisers on both clock sources
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fc_s1 <= 1'b0;
            fc_s2 <= 1'b0;
            fc_s3 <= 1'b0;
            sc_s1 <= 1'b0;
            sc_s2 <= 1'b0;
            sc_s3 <= 1'b0;
        end else if (ce) begin
            fc_s1 <= fast_clock_source;
            fc_s2 <= fc_s1;
            fc_s3 <= fc_s2;
            sc_s1 <= slow_clock_source;
            sc_s2 <= sc_s1;
            sc_s3 <= sc_s2;
        end
    end

    // Accept a new level only when stages two and three agree
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fc_level_r <= 1'b0;
            sc_level_r <= 1'b0;
        end else if (ce) begin
            if (fc_s2 == fc_s3) begin
                fc_level_r <= fc_s2;
            end
            if (sc_s2 == sc_s3) begin
                sc_level_r <= sc_s2;
            end
        end
    end

    // All transmit timing hangs off this edge
    assign fall_edge = ce && fc_s2 == fc_s3 && fc_level_r && !fc_s2;

    // Clocks forwarded to pins; single-edge mode sends the fast clock as shift clock
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shift_clk_r <= 1'b0;
        end else if (ce) begin
            shift_clk_r <= ctrl_r[lds_pkg::CTRL_SINGLE_EDGE] ? fc_level_r : sc_level_r;
        end
    end
    assign double_rate_clock_out = fc_level_r;
    assign shift_clock_out = shift_clk_r;

    // Register address decode
    assign wr_ctrl = reg_wr && reg_addr == lds_pkg::OFS_CTRL;
    assign wr_len = reg_wr && reg_addr == lds_pkg::OFS_LEN;
    assign wr_data = reg_wr && reg_addr == lds_pkg::OFS_DATA;
    assign wr_status = reg_wr && reg_addr == lds_pkg::OFS_STATUS;

    // Control and length registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_r <= lds_pkg::CTRL_RESET;
            len_r <= lds_pkg::LEN_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl_r <= reg_wdata[lds_pkg::CTRL_W-1:0];
            end
            if (wr_len) begin
                len_r <= reg_wdata[lds_pkg::LEN_W-1:0];
            end
        end
    end

    // Only the broadcast bit leaves the block as the shared start
    assign sync_start_out = ctrl_r[lds_pkg::CTRL_BCAST_GO];
    // Local bit or the shared line starts a frame
    assign transfer_start = ctrl_r[lds_pkg::CTRL_LOCAL_GO] || ext_start_in;

    // Frame sequencer next state
    always_comb begin
        case (state_r)
            lds_pkg::LDS_IDLE: begin
                state_nxt = (transfer_start && !word_count_match) ?
                    lds_pkg::LDS_ACTIVE : lds_pkg::LDS_IDLE;
            end
            lds_pkg::LDS_ACTIVE: begin
                state_nxt = word_count_match ? lds_pkg::LDS_END : lds_pkg::LDS_ACTIVE;
            end
            lds_pkg::LDS_END: begin
                state_nxt = transfer_start ? lds_pkg::LDS_END : lds_pkg::LDS_IDLE;
            end
            default: begin
                state_nxt = lds_pkg::LDS_IDLE;
            end
        endcase
    end

    // Frame sequencer state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r <= lds_pkg::LDS_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Low only while transmitting
    assign not_active = state_r != lds_pkg::LDS_ACTIVE;

    // Words left: head word plus programmed data words
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wcnt_r <= lds_pkg::WCNT_ZERO;
        end else if (ce) begin
            if (state_r == lds_pkg::LDS_IDLE) begin
                wcnt_r <= {1'b0, len_r} + lds_pkg::WCNT_ONE;
            end else if (bit_count_match && wcnt_r != lds_pkg::WCNT_ZERO) begin
                wcnt_r <= wcnt_r - lds_pkg::WCNT_ONE;
            end
        end
    end
    assign word_count_match = wcnt_r == lds_pkg::WCNT_ZERO;

    // Bit position within the 17-bit slot
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bit_idx_r <= lds_pkg::FIRST_BIT_IDX;
        end else if (ce) begin
            if (not_active) begin
                bit_idx_r <= lds_pkg::FIRST_BIT_IDX;
            end else if (fall_edge) begin
                bit_idx_r <= (bit_idx_r == lds_pkg::LAST_BIT_IDX) ?
                    lds_pkg::FIRST_BIT_IDX : bit_idx_r + 5'h01;
            end
        end
    end
    assign bit_count_match = fall_edge && !not_active &&
        bit_idx_r == lds_pkg::LAST_BIT_IDX;

    // First slot of a frame carries the all-ones head word
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            head_r <= 1'b1;
        end else if (ce) begin
            if (not_active) begin
                head_r <= 1'b1;
            end else if (bit_count_match) begin
                head_r <= 1'b0;
            end
        end
    end

    // Queue pull at the start of each data slot
    assign q_empty = q_lvl_r == 3'h0;
    assign q_starve = fall_edge && !not_active && !head_r &&
        bit_idx_r == lds_pkg::FIRST_BIT_IDX;
    assign q_pop = q_starve && !q_empty;
    assign q_push = ce && wr_data && q_lvl_r != lds_pkg::QLVL_FULL;

    // Queue storage
    always_ff @(posedge clock) begin
        if (q_push) begin
            q_mem[q_wr_r] <= reg_wdata[lds_pkg::WORD_W-1:0];
        end
    end

    // Queue pointers and level
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q_wr_r <= '0;
            q_rd_r <= '0;
            q_lvl_r <= '0;
        end else if (ce) begin
            if (q_push) begin
                q_wr_r <= q_wr_r + lds_pkg::QPTR_ONE;
            end
            if (q_pop) begin
                q_rd_r <= q_rd_r + lds_pkg::QPTR_ONE;
            end
            if (q_push && !q_pop) begin
                q_lvl_r <= q_lvl_r + lds_pkg::QLVL_ONE;
            end else if (q_pop && !q_push) begin
                q_lvl_r <= q_lvl_r - lds_pkg::QLVL_ONE;
            end
        end
    end

    // Sticky queue errors; a new error wins over the clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            overflow_r <= 1'b0;
            underflow_r <= 1'b0;
        end else if (ce) begin
            if (wr_data && q_lvl_r == lds_pkg::QLVL_FULL) begin
                overflow_r <= 1'b1;
            end else if (wr_status && reg_wdata[lds_pkg::STAT_OVERFLOW]) begin
                overflow_r <= 1'b0;
            end
            if (q_starve && q_empty) begin
                underflow_r <= 1'b1;
            end else if (wr_status && reg_wdata[lds_pkg::STAT_UNDERFLOW]) begin
                underflow_r <= 1'b0;
            end
        end
    end

    // Drive the shifter lane
    assign lane.edge_fall = fall_edge;
    assign lane.active = !not_active;
    assign lane.bit_idx = bit_idx_r;
    assign lane.load_word = head_r ? lds_pkg::HEAD_WORD :
        (q_empty ? '0 : q_mem[q_rd_r]);

    // Shifter
    lds_shift_serializer u_ser (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .lane(lane)
    );
    assign serial_out_pin = lane.sdo;

    // Four-word group counter
    lds_word_group_counter u_grp (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .not_active(not_active),
        .bit_match(bit_count_match),
        .group_event(group_done_event)
    );

    // Frame end event as the sequencer leaves the active state
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frame_done_r <= 1'b0;
        end else begin
            frame_done_r <= ce && state_r == lds_pkg::LDS_ACTIVE &&
                state_nxt == lds_pkg::LDS_END;
        end
    end
    assign frame_done_event = frame_done_r;

    // Read data, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (ce) begin
            if (!reg_rd) begin
                reg_rdata <= '0;
            end else if (reg_addr == lds_pkg::OFS_CTRL) begin
                reg_rdata <= {29'h0, ctrl_r};
            end else if (reg_addr == lds_pkg::OFS_LEN) begin
                reg_rdata <= {24'h0, len_r};
            end else if (reg_addr == lds_pkg::OFS_STATUS) begin
                reg_rdata <= {8'h0, wcnt_r, 3'h0, bit_idx_r, q_lvl_r, state_r,
                    underflow_r, overflow_r};
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    default clocking dflt @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_idle_start: assert property (
        (ce && state_r == lds_pkg::LDS_IDLE && transfer_start && !word_count_match)
        |=> state_r == lds_pkg::LDS_ACTIVE)
        else $error("idle did not start");
    a_idle_stay: assert property (
        (ce && state_r == lds_pkg::LDS_IDLE && !(transfer_start && !word_count_match))
        |=> state_r == lds_pkg::LDS_IDLE)
        else $error("idle left without start");
    a_active_end: assert property (
        (ce && state_r == lds_pkg::LDS_ACTIVE)
        |=> state_r == ($past(word_count_match) ? lds_pkg::LDS_END : lds_pkg::LDS_ACTIVE))
        else $error("active exit wrong");
    a_end_release: assert property (
        (ce && state_r == lds_pkg::LDS_END)
        |=> state_r == ($past(transfer_start) ? lds_pkg::LDS_END : lds_pkg::LDS_IDLE))
        else $error("end exit wrong");
    a_bit_reset: assert property (
        (ce && not_active) |=> bit_idx_r == 5'h00)
        else $error("bit counter runs outside frame");
    a_word_dec: assert property (
        (ce && state_r == lds_pkg::LDS_ACTIVE && bit_count_match && wcnt_r != 9'h000)
        |=> wcnt_r == $past(wcnt_r) - 9'h001)
        else $error("word counter did not step");
    a_bit_step: assert property (
        (ce && !not_active && fall_edge && bit_idx_r != 5'h10)
        |=> bit_idx_r == $past(bit_idx_r) + 5'h01)
        else $error("bit counter did not step");
    a_frame_event: assert property (
        frame_done_event |-> (state_r == lds_pkg::LDS_END && $past(state_r) == lds_pkg::LDS_ACTIVE))
        else $error("frame event misplaced");
    a_clock_pass: assert property (
        (ce && fc_s2 == fc_s3) |=> double_rate_clock_out == $past(fc_s2))
        else $error("double-rate clock not forwarded");
endmodule : lds_tx_top

/* File: logic/lds_pkg.sv */
package lds_pkg;
    // Word geometry
    localparam int WORD_W = 16;
    localparam int BIT_IDX_W = 5;
    localparam logic [4:0] LAST_BIT_IDX = 5'h10;
    localparam logic [4:0] FIRST_BIT_IDX = 5'h00;
    localparam logic [15:0] HEAD_WORD = 16'hFFFF;
    localparam logic IDLE_LEVEL = 1'b1;
    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_LEN = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    // Control fields
    localparam int CTRL_LOCAL_GO = 0;
    localparam int CTRL_BCAST_GO = 1;
    localparam int CTRL_SINGLE_EDGE = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // Status fields
    localparam int STAT_OVERFLOW = 0;
    localparam int STAT_UNDERFLOW = 1;
    // Frame length and word counter
    localparam int LEN_W = 8;
    localparam logic [7:0] LEN_RESET = 8'h01;
    localparam int WCNT_W = 9;
    localparam logic [8:0] WCNT_ONE = 9'h001;
    localparam logic [8:0] WCNT_ZERO = 9'h000;
    // Transmit word queue
    localparam int QUEUE_DEPTH = 4;
    localparam int QPTR_W = 2;
    localparam int QLVL_W = 3;
    localparam logic [2:0] QLVL_FULL = 3'h4;
    localparam logic [1:0] QPTR_ONE = 2'h1;
    localparam logic [2:0] QLVL_ONE = 3'h1;
    // Word group counter
    localparam logic [1:0] GROUP_LAST = 2'h3;
    // Frame sequencer states, encoded 00, 01, 10, 11 in order
    typedef enum logic [1:0] {LDS_IDLE, LDS_ACTIVE, LDS_END, LDS_ILLEGAL} lds_seq_e;
endpackage : lds_pkg

/* File: logic/lds_lane_if.sv */
`timescale 1ns/1ps
interface lds_lane_if;
    logic edge_fall;
    logic active;
    logic [4:0] bit_idx;
    logic [15:0] load_word;
    logic sdo;
    // Frame control side
    modport ctrl (output edge_fall, output active, output bit_idx, output load_word,
        input sdo);
    // Shifter side
    modport shifter (input edge_fall, input active, input bit_idx, input load_word,
        output sdo);
endinterface : lds_lane_if

/* File: logic/lds_word_group_counter.sv */
`timescale 1ns/1ps
module lds_word_group_counter (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // Frame status
    input wire logic not_active,
    input wire logic bit_match,
    // Event out
    output logic group_event
);
    // Words seen in current group
    logic [1:0] grp_r;

    // Advance per word, forced to zero outside frames
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            grp_r <= 2'h0;
        end else if (ce) begin
            if (not_active) begin
                grp_r <= 2'h0;
            end else if (bit_match) begin
                grp_r <= grp_r + 2'h1;
            end
        end
    end

    // Pulse when the fourth word closes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            group_event <= 1'b0;
        end else begin
            group_event <= ce && !not_active && bit_match && grp_r == lds_pkg::GROUP_LAST;
        end
    end

    a_group_forced: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && not_active) |=> (grp_r == 2'h0 && !group_event))
        else $error("group counter not cleared");
    a_group_hold: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && !not_active && !bit_match) |=> $stable(grp_r))
        else $error("group counter moved without match");
    a_group_event: assert property (@(posedge clock) disable iff (sys_rst)
        group_event |-> ($past(grp_r) == 2'h3 && grp_r == 2'h0))
        else $error("group event not at fourth word");
endmodule : lds_word_group_counter

/* File: logic/lds_shift_serializer.sv */
`timescale 1ns/1ps
module lds_shift_serializer (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    // Lane from frame control
    lds_lane_if.shifter lane
);
    // Remaining bits of the word
    logic [15:0] shift_r;
    // Last data bit, source of the check bit
    logic last_r;
    // Line level
    logic sdo_r;

    assign lane.sdo = sdo_r;

    // One bit per falling edge of the double-rate clock
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shift_r <= '0;
            last_r <= 1'b0;
            sdo_r <= lds_pkg::IDLE_LEVEL;
        end else if (ce && lane.edge_fall) begin
            if (!lane.active) begin
                sdo_r <= lds_pkg::IDLE_LEVEL;
            end else if (lane.bit_idx == lds_pkg::FIRST_BIT_IDX) begin
                sdo_r <= lane.load_word[15];
                shift_r <= {lane.load_word[14:0], 1'b0};
                last_r <= lane.load_word[0];
            end else if (lane.bit_idx == lds_pkg::LAST_BIT_IDX) begin
                // Check bit is the inverse of the last data bit
                sdo_r <= !last_r;
            end else begin
                sdo_r <= shift_r[15];
                shift_r <= {shift_r[14:0], 1'b0};
            end
        end
    end

    a_line_idle: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && lane.edge_fall && !lane.active) |=> sdo_r)
        else $error("line not high outside frame");
    a_check_bit: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && lane.edge_fall && lane.active && lane.bit_idx == 5'h10)
        |=> (sdo_r == !$past(last_r)))
        else $error("check bit wrong");
    a_first_bit: assert property (@(posedge clock) disable iff (sys_rst)
        (ce && lane.edge_fall && lane.active && lane.bit_idx == 5'h00)
        |=> (sdo_r == $past(lane.load_word[15])))
        else $error("first data bit wrong");
endmodule : lds_shift_serializer

/* File: tb/lds_led_rx_model.sv */
`timescale 1ns/1ps
module lds_led_rx_model (
    // Sampling clock
    input wire logic clock,
    // Serial bus from the transmitter
    input wire logic sclk_x2,
    input wire logic sdo
);
    logic prev_r = 1'b0; // Last seen level of the bus clock
    logic busy_r = 1'b0; // Inside a frame
    logic [16:0] slot_r = 17'h00000; // Bits of the current slot
    int nbits = 0; // Bits gathered so far in the slot
    logic [15:0] words[$]; // Data words received
    int chk_err = 0; // Slots with a wrong check bit
    // Take one bit on each rising bus clock edge, midway between shifts
    always @(posedge clock) begin
        if (sclk_x2 && !prev_r) begin
            if (!busy_r) begin
                // Idle ones end at the first zero
                busy_r = (sdo == 1'b0);
                nbits = 0;
            end else begin
                slot_r = {slot_r[15:0], sdo};
                nbits++;
                if (nbits == 17) begin
                    nbits = 0;
                    if (slot_r == 17'h1FFFF) begin
                        // A full slot of ones is the end mark
                        busy_r = 1'b0;
                    end else begin
                        // MSB first word, then its check bit
                        words.push_back(slot_r[16:1]);
                        if (slot_r[0] !== ~slot_r[1]) chk_err++;
                    end
                end
            end
        end
        prev_r = sclk_x2;
    end
endmodule : lds_led_rx_model

/* File: tb/lds_tx_top_tb.sv */
`timescale 1ns/1ps
module lds_tx_top_tb;
    // Design inputs
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fast_clock_source = 1'b0;
    logic slow_clock_source = 1'b0;
    logic ext_start_in = 1'b0;
    // Design outputs
    logic [31:0] reg_rdata;
    logic sync_start_out, serial_out_pin, double_rate_clock_out, shift_clock_out;
    logic group_done_event, frame_done_event;
    // Bookkeeping
    int num_errors = 0;
    int n_compared = 0;
    int n_grp = 0;
    int n_fd = 0;
    int n, k, c;
    logic [15:0] exp_q[$];
    logic [15:0] w;
    logic [31:0] st;
    lds_tx_top lds_tx_top_i (.clock(clock), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fast_clock_source(fast_clock_source), .slow_clock_source(slow_clock_source),
        .ext_start_in(ext_start_in), .sync_start_out(sync_start_out),
        .serial_out_pin(serial_out_pin), .double_rate_clock_out(double_rate_clock_out),
        .shift_clock_out(shift_clock_out), .group_done_event(group_done_event),
        .frame_done_event(frame_done_event));
    lds_led_rx_model lds_led_rx_model_i (.clock(clock), .sclk_x2(double_rate_clock_out),
        .sdo(serial_out_pin));
    // System clock, 4 ns
    initial begin
        forever #2 clock = ~clock;
    end
    // Bus clocks, free running, phase unrelated to the system clock
    initial begin
        #1.3;
        forever #32 fast_clock_source = ~fast_clock_source;
    end
    initial begin
        #1.3;
        forever #64 slow_clock_source = ~slow_clock_source;
    end
    // Count event pulses
    always @(posedge clock) begin
        if (group_done_event === 1'b1) n_grp++;
        if (frame_done_event === 1'b1) n_fd++;
    end
    // Register write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // Register read, data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    // Compare and report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk
    // Counts and verdict
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // Rising edges of a forwarded clock over 512 cycles
    task automatic rises(input bit dr, output int cnt);
        logic p, s;
        cnt = 0;
        p = dr ? double_rate_clock_out : shift_clock_out;
        repeat (512) begin
            @(posedge clock);
            s = dr ? double_rate_clock_out : shift_clock_out;
            if (s && !p) cnt++;
            p = s;
        end
    endtask : rises
    // One frame of n words, npush of them pushed here, the rest queue misses
    task automatic run_frame(input int n, input int npush, input bit ext);
        int t;
        n_grp = 0;
        n_fd = 0;
        lds_led_rx_model_i.words.delete();
        wr(lds_pkg::OFS_LEN, 32'(n));
        while (exp_q.size() < npush) begin
            exp_q.push_back(16'($urandom));
            wr(lds_pkg::OFS_DATA, {16'h0, exp_q[$]});
        end
        while (exp_q.size() < n) exp_q.push_back(16'h0000);
        if (ext) begin
            @(posedge clock);
            ext_start_in <= 1'b1;
        end else wr(lds_pkg::OFS_CTRL, 32'h1);
        t = 0;
        while (n_fd == 0 && t < 4000) begin
            @(posedge clock);
            t++;
        end
        if (t == 4000) begin
            $display("[FAIL] frame end expected 1 seen 0");
            num_errors++;
            close_out();
        end
        rd(lds_pkg::OFS_STATUS, st);
        chk("state end", 2, st[3:2]);
        if (ext) begin
            @(posedge clock);
            ext_start_in <= 1'b0;
        end else wr(lds_pkg::OFS_CTRL, 32'h0);
        repeat (300) @(posedge clock);
        rd(lds_pkg::OFS_STATUS, st);
        chk("state idle", 0, st[3:2]);
        chk("group events", (n + 1) / 4, n_grp);
        chk("frame events", 1, n_fd);
        chk("word count", n, lds_led_rx_model_i.words.size());
        for (t = 0; t < n; t++) chk("word", exp_q[t], lds_led_rx_model_i.words[t]);
        chk("check bits", 0, lds_led_rx_model_i.chk_err);
        exp_q.delete();
        $display("test frame of %0d words done", n);
    endtask : run_frame
    // Main sequence
    initial begin
        void'($urandom(32'hB5FCF231));
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk("idle line", 1, serial_out_pin);
        chk("sync out", 0, sync_start_out);
        rd(lds_pkg::OFS_LEN, st);
        chk("len reset", 1, st);
        rd(lds_pkg::OFS_STATUS, st);
        // Idle reloads the word counter with length plus head slot, field at bit 15
        chk("status reset", 32'(lds_pkg::LEN_RESET + 1) << 15, st);
        rd(4'h2, st);
        chk("unmapped", 0, st);
        $display("test reset done");
        // Enable low: a control write must not be taken
        @(posedge clock);
        ce <= 1'b0;
        wr(lds_pkg::OFS_CTRL, 32'h4);
        @(posedge clock);
        ce <= 1'b1;
        rd(lds_pkg::OFS_CTRL, st);
        chk("ce freeze", 0, st);
        $display("test enable done");
        run_frame(1, 1, 0);
        run_frame(3, 3, 0);
        run_frame(4, 4, 0);
        n = 1 + int'($urandom % 4);
        run_frame(n, n, 1);
        run_frame(2, 1, 0);
        rd(lds_pkg::OFS_STATUS, st);
        chk("underflow", 1, st[1]);
        wr(lds_pkg::OFS_STATUS, 32'h3);
        for (k = 0; k < 5; k++) begin
            w = 16'($urandom);
            if (k < 4) exp_q.push_back(w);
            wr(lds_pkg::OFS_DATA, {16'h0, w});
        end
        rd(lds_pkg::OFS_STATUS, st);
        chk("overflow", 1, st[0]);
        wr(lds_pkg::OFS_STATUS, 32'h3);
        run_frame(4, 0, 0);
        wr(lds_pkg::OFS_CTRL, 32'h2);
        repeat (2) @(posedge clock);
        chk("sync out", 1, sync_start_out);
        wr(lds_pkg::OFS_CTRL, 32'h0);
        rises(1'b1, c);
        chk("fast pin rises", 32, (c > 30 && c < 34) ? 32 : c);
        rises(1'b0, c);
        chk("slow pin rises", 16, (c > 14 && c < 18) ? 16 : c);
        wr(lds_pkg::OFS_CTRL, 32'h4);
        rises(1'b0, c);
        chk("single edge rises", 32, (c > 30 && c < 34) ? 32 : c);
        wr(lds_pkg::OFS_CTRL, 32'h0);
        $display("test clocks done");
        close_out();
    end
endmodule : lds_tx_top_tb
